// [dv/scc_capture_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module scc_checker
    import scc_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              sysref_in,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              sysref_capture
);
    logic [7:0] hist_q;
    logic [1:0] off_q;
    always_ff @(posedge core_clk) hist_q <= {hist_q[6:0], sysref_in};
    // Cycles since capture was switched off, saturating at three
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) off_q <= 2'h0;
        else if (reg_wr_en && reg_addr == ADDR_CAPTURE_SETUP)
            off_q <= (reg_wdata[2:1] == MODE_DISABLED) ? 2'h1 : 2'h0;
        else if (off_q != 2'h0 && off_q != 2'h3) off_q <= off_q + 2'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_pulse_one; sysref_capture |=> !sysref_capture; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("capture too long");
    // Either clock edge choice must land within this span
    property p_cause; sysref_capture |-> !(hist_q[5:2] inside {4'h0, 4'hf}); endproperty
    a_cause: assert property (p_cause) else $error("capture without pulse");
    property p_setup_rb; reg_wr_en && reg_addr == ADDR_CAPTURE_SETUP ##1 reg_rd_en
        && !reg_wr_en && reg_addr == ADDR_CAPTURE_SETUP
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h5e); endproperty
    a_setup_rb: assert property (p_setup_rb) else $error("setup readback");
    property p_skip_rb; reg_wr_en && reg_addr == ADDR_SKIP_COUNT_CTL ##1 reg_rd_en
        && !reg_wr_en && reg_addr == ADDR_SKIP_COUNT_CTL
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f); endproperty
    a_skip_rb: assert property (p_skip_rb) else $error("skip readback");
    property p_win_rb; reg_wr_en && reg_addr == ADDR_EARLY_WINDOW ##1 reg_rd_en
        && !reg_wr_en && reg_addr == ADDR_EARLY_WINDOW
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0c); endproperty
    a_win_rb: assert property (p_win_rb) else $error("window readback");
    property p_flag_clr; reg_wr_en && reg_addr == ADDR_CAPTURE_SETUP
        && reg_wdata[FLAG_RST_POS] ##1 reg_rd_en && reg_addr == ADDR_CAPTURE_COUNT
        |=> reg_rdata == 8'h00; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("count not cleared");
    property p_disabled; off_q == 2'h3 |-> !sysref_capture; endproperty
    a_disabled: assert property (p_disabled) else $error("capture while off");
    property p_rd_stands; !reg_rd_en |=> $stable(reg_rdata); endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
endmodule
bind scc_capture_ctrl scc_checker i_scc_checker (.core_clk(core_clk), .rst_b(rst_b),
    .sysref_in(sysref_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .sysref_capture(sysref_capture));
`default_nettype wire

// [dv/scc_sysref_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scc_sysref_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic [3:0] high_len,
    output logic            sysref
);
    logic [3:0] cnt;
    // Timing source moves its pin on the falling clock edge
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) cnt <= 4'h0;
        else if (start) cnt <= high_len;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign sysref = (cnt != 4'h0);
endmodule
`default_nettype wire

// [dv/sysref_capture_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sysref_capture_control_tb;
    import scc_pkg::*;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              start = 1'b0;
    logic [3:0]        hl = 4'h0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic              sref;
    logic              cap;
    int                fail_count = 0;
    int                checks = 0;
    int                e_n;
    int                l_n;
    always #5 core_clk = ~core_clk;
    scc_capture_ctrl i_scc_capture_ctrl (.core_clk(core_clk), .rst_b(rst_b), .sysref_in(sref),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_rdata(rdata), .sysref_capture(cap));
    scc_sysref_model i_scc_sysref_model (.core_clk(core_clk), .rst_b(rst_b), .start(start),
        .high_len(hl), .sysref(sref));
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wrr(logic [11:0] a, logic [7:0] d);
        addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rdr(logic [11:0] a, logic [7:0] exp);
        addr <= a; rd <= 1'b1; wr <= 1'b0;
        @(negedge core_clk);
        cmp($sformatf("reg %h", a), exp, rdata);
    endtask
    // Early span holds rise captures of an 8 long pulse, late span its fall
    task automatic burst(logic [3:0] h, int exp_e, int exp_l);
        wr <= 1'b0; rd <= 1'b0; hl <= h; start <= 1'b1; e_n = 0; l_n = 0;
        @(negedge core_clk); start <= 1'b0;
        repeat (8) begin @(negedge core_clk); e_n += cap; end
        repeat (12) begin @(negedge core_clk); l_n += cap; end
        cmp("early captures", 8'(exp_e), 8'(e_n));
        cmp("late captures", 8'(exp_l), 8'(l_n));
    endtask
    task automatic nshot(logic [3:0] k);
        wrr(ADDR_SKIP_COUNT_CTL, {4'h0, k});
        wrr(ADDR_CAPTURE_SETUP, 8'h04);
        for (int i = 0; i <= k + 1; i++) burst(4'h8, int'(i == k), 0);
    endtask
    task automatic conclude;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100us fail_count++;
        conclude;
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        rdr(ADDR_CAPTURE_SETUP, 8'h00);
        rdr(ADDR_EARLY_WINDOW, 8'h00);
        rdr(ADDR_CAPTURE_COUNT, 8'h00);
        wrr(12'h123, 8'hff);
        rdr(12'h123, 8'h00);
        wrr(ADDR_CAPTURE_SETUP, 8'hff);
        rdr(ADDR_CAPTURE_SETUP, 8'h5e);
        wrr(ADDR_SKIP_COUNT_CTL, 8'hff);
        rdr(ADDR_SKIP_COUNT_CTL, 8'h0f);
        wrr(ADDR_EARLY_WINDOW, 8'hff);
        rdr(ADDR_EARLY_WINDOW, 8'h0c);
        wrr(ADDR_EARLY_WINDOW, 8'h00);
        wrr(ADDR_CAPTURE_SETUP, 8'h02);
        burst(4'h8, 1, 0);
        burst(4'h8, 1, 0);
        wrr(ADDR_CAPTURE_SETUP, 8'h00);
        rdr(ADDR_CAPTURE_COUNT, 8'h02);
        wrr(ADDR_CAPTURE_SETUP, 8'h40);
        rdr(ADDR_CAPTURE_COUNT, 8'h00);
        wrr(ADDR_CAPTURE_SETUP, 8'h12);
        burst(4'h8, 0, 1);
        wrr(ADDR_CAPTURE_SETUP, 8'h00);
        wrr(ADDR_CAPTURE_SETUP, 8'h0a);
        burst(4'h8, 1, 0);
        nshot(4'h0);
        nshot(4'hf);
        wrr(ADDR_CAPTURE_SETUP, 8'h06);
        burst(4'h8, 1, 0);
        burst(4'h8, 0, 0);
        wrr(ADDR_CAPTURE_SETUP, 8'h06);
        burst(4'h8, 1, 0);
        wrr(ADDR_CAPTURE_SETUP, 8'h00);
        wrr(ADDR_CAPTURE_SETUP, 8'h12);
        wrr(ADDR_EARLY_WINDOW, 8'h0c);
        burst(4'h1, 0, 0);
        rdr(ADDR_CAPTURE_STATUS, 8'h01);
        burst(4'h8, 0, 1);
        wrr(ADDR_EARLY_WINDOW, 8'h00);
        burst(4'h1, 1, 0);
        wrr(ADDR_CAPTURE_SETUP, 8'h00);
        burst(4'h8, 0, 0);
        conclude;
    end
endmodule
`default_nettype wire

// [rtl/scc_capture_ctrl.sv]
// What this block does
// RULE1: Bit 4 picks rising or falling pulse.
// RULE2: Software disables capture before changing polarity.
// RULE3: Bit 3 picks rising or falling clock edge.
// RULE4: Mode bits 2:1: off, continuous, N-shot, next.
// RULE5: N-shot skips first N transitions, acts next.
// RULE6: Early window bits 3:2 reject early transitions.
// RULE7: Each window code step adds one cycle.
// RULE8: N-shot stops after one capture until rearmed.
// RULE9: Flag reset holds error flags cleared.
// RULE10: 8-bit wrapping capture count, cleared by reset.
`timescale 1ns/1ps
`default_nettype none

module scc_capture_ctrl
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Alignment pulse pin
    input  wire logic              sysref_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    output logic      [DATA_W-1:0] reg_rdata,
    // Capture result
    output logic                   sysref_capture
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              flag_rst;
        logic              pulse_polarity_bit;
        logic              edge_sel;
        logic [MODE_W-1:0] capture_mode_field;
        logic [SKIP_W-1:0] skip_transition_count;
        logic [WIN_W-1:0]  early_reject_window;
        logic              armed;
        logic [SKIP_W-1:0] skipped;
        logic              prev_lvl;
        logic [WIN_W-1:0]  run;
        logic              reject_flag;
        logic [COUNT_W-1:0] count;
        logic              pulse;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rise_sync;
        logic [1:0]        fall_sync;
    } scc_state_type;

    scc_state_type st_q;
    scc_state_type st_d;
    logic          fall_smp_q;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] target);
        addr_is = (a == target);
    endfunction

    // ****************************************************************
    // Falling-edge sample
    // ****************************************************************
    // Kept outside the state record: it lives on the opposite clock phase
    always_ff @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fall_smp_q <= 1'b0;
        end else begin
            fall_smp_q <= sysref_in;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic lvl;
        logic changed;
        logic qualify;
        logic early;
        logic act;
        logic clear_now;
        st_d    = st_q;
        clear_now = 1'b0;
        lvl     = 1'b0;
        changed = 1'b0;
        qualify = 1'b0;
        early   = 1'b0;
        act     = 1'b0;

        st_d.rise_sync = {st_q.rise_sync[0], sysref_in};
        st_d.fall_sync = {st_q.fall_sync[0], fall_smp_q};
        st_d.pulse     = 1'b0;

        // ************************************************************
        // Transition detect
        // ************************************************************
        // Clock edge choice
        lvl = st_q.edge_sel ? st_q.fall_sync[1] : st_q.rise_sync[1];  // RULE3
        changed = (lvl != st_q.prev_lvl);
        // Cleared bit: low-to-high is the active transition
        qualify = changed && (lvl == !st_q.pulse_polarity_bit);       // RULE1
        // Previous level held run+1 cycles; too short means early
        early = (st_q.run < st_q.early_reject_window);                // RULE6 RULE7
        st_d.prev_lvl = lvl;
        if (changed) begin
            st_d.run = '0;
        end else if (st_q.run != RUN_MAX) begin
            st_d.run = st_q.run + 1'b1;
        end

        // ************************************************************
        // Capture decision
        // ************************************************************
        if (qualify && early) begin
            st_d.reject_flag = 1'b1;
        end else if (qualify) begin
            unique case (st_q.capture_mode_field)                      // RULE4
                MODE_DISABLED: begin
                    act = 1'b0;
                end
                MODE_CONTINUOUS: begin
                    act = 1'b1;
                end
                MODE_NSHOT: begin
                    if (st_q.armed) begin
                        if (st_q.skipped == st_q.skip_transition_count) begin  // RULE5
                            act = 1'b1;
                            st_d.armed = 1'b0;                         // RULE8
                        end else begin
                            st_d.skipped = st_q.skipped + 1'b1;
                        end
                    end
                end
                MODE_NEXT: begin
                    if (st_q.armed) begin
                        act = 1'b1;
                        st_d.armed = 1'b0;
                    end
                end
            endcase
        end

        if (act) begin
            st_d.pulse = 1'b1;
            st_d.count = st_q.count + 1'b1;                           // RULE10
        end

        // ************************************************************
        // Register writes
        // ************************************************************
        // A mode write rearms the single-shot modes
        if (reg_wr_en) begin
            if (addr_is(reg_addr, ADDR_CAPTURE_SETUP)) begin
                st_d.flag_rst           = reg_wdata[FLAG_RST_POS];
                // Polarity is only expected to change while disabled
                st_d.pulse_polarity_bit = reg_wdata[POLARITY_POS];   // RULE2
                st_d.edge_sel           = reg_wdata[EDGE_SEL_POS];
                st_d.capture_mode_field = reg_wdata[MODE_LSB +: MODE_W];
                st_d.armed   = (reg_wdata[MODE_LSB +: MODE_W] != MODE_DISABLED);  // RULE8
                st_d.skipped = '0;
            end
            if (addr_is(reg_addr, ADDR_SKIP_COUNT_CTL)) begin
                st_d.skip_transition_count = reg_wdata[SKIP_LSB +: SKIP_W];
            end
            if (addr_is(reg_addr, ADDR_EARLY_WINDOW)) begin
                st_d.early_reject_window = reg_wdata[WIN_LSB +: WIN_W];
            end
        end

        // ************************************************************
        // Clear control
        // ************************************************************
        // Clear starts with the write itself, so a read right behind it sees zero
        clear_now = st_q.flag_rst
                    || (reg_wr_en && addr_is(reg_addr, ADDR_CAPTURE_SETUP)
                        && reg_wdata[FLAG_RST_POS]);
        // Held clear for as long as the bit stays set
        if (clear_now) begin
            st_d.reject_flag = 1'b0;                                  // RULE9
            st_d.count       = '0;                                    // RULE10
        end

        // ************************************************************
        // Read data
        // ************************************************************
        // Registered read data, one cycle after the strobe
        if (reg_rd_en) begin
            st_d.rdata = RESET_VALUE;
            if (addr_is(reg_addr, ADDR_CAPTURE_SETUP)) begin
                st_d.rdata[FLAG_RST_POS]          = st_q.flag_rst;
                st_d.rdata[POLARITY_POS]          = st_q.pulse_polarity_bit;
                st_d.rdata[EDGE_SEL_POS]          = st_q.edge_sel;
                st_d.rdata[MODE_LSB +: MODE_W]    = st_q.capture_mode_field;
            end
            if (addr_is(reg_addr, ADDR_SKIP_COUNT_CTL)) begin
                st_d.rdata[SKIP_LSB +: SKIP_W]    = st_q.skip_transition_count;
            end
            if (addr_is(reg_addr, ADDR_EARLY_WINDOW)) begin
                st_d.rdata[WIN_LSB +: WIN_W]      = st_q.early_reject_window;
            end
            if (addr_is(reg_addr, ADDR_CAPTURE_STATUS)) begin
                st_d.rdata[REJECT_POS]            = st_q.reject_flag;
            end
            if (addr_is(reg_addr, ADDR_CAPTURE_COUNT)) begin
                st_d.rdata = st_q.count;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata      = st_q.rdata;
    assign sysref_capture = st_q.pulse;

endmodule

`default_nettype wire

// [rtl/scc_pkg.sv]
// ****************************************************************
// Capture control constants
// ****************************************************************
package scc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_SETUP   = 12'h120;
    localparam logic [ADDR_W-1:0] ADDR_SKIP_COUNT_CTL  = 12'h121;
    localparam logic [ADDR_W-1:0] ADDR_EARLY_WINDOW    = 12'h122;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_STATUS  = 12'h128;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURE_COUNT   = 12'h12a;

    // Field positions in sysref_capture_setup
    localparam int FLAG_RST_POS  = 6;
    localparam int POLARITY_POS  = 4;
    localparam int EDGE_SEL_POS  = 3;
    localparam int MODE_LSB      = 1;
    localparam int MODE_W        = 2;

    // Field positions in the other control registers
    localparam int SKIP_LSB      = 0;
    localparam int SKIP_W        = 4;
    localparam int WIN_LSB       = 2;
    localparam int WIN_W         = 2;
    localparam int REJECT_POS    = 0;

    localparam int COUNT_W       = 8;
    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

    // Capture mode codes
    localparam logic [MODE_W-1:0] MODE_DISABLED   = 2'h0;
    localparam logic [MODE_W-1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [MODE_W-1:0] MODE_NSHOT      = 2'h2;
    localparam logic [MODE_W-1:0] MODE_NEXT       = 2'h3;

    // Run-length counter saturates at the widest early window
    localparam logic [WIN_W-1:0] RUN_MAX = 2'h3;

endpackage
